// file: hdl/cam_defines.svh
// constants for the content-addressable memory
`ifndef CAM_DEFINES_SVH
`define CAM_DEFINES_SVH
`define CAM_DEPTH      32
`define CAM_WIDTH      32
`define CAM_ADDR_W     5
`define CAM_SEARCH_LAT 1
`endif

// file: hdl/cam_pkg.sv
// types shared by the content-addressable memory files
`include "cam_defines.svh"
package cam_pkg;
   typedef struct packed {
      logic                    en;
      logic [`CAM_ADDR_W-1:0]  addr;
      logic [`CAM_WIDTH-1:0]   data;
      logic [`CAM_WIDTH-1:0]   care;
   } cam_write_t;
   typedef struct packed {
      logic                    en;
      logic [`CAM_WIDTH-1:0]   key;
   } cam_search_t;
   typedef struct packed {
      logic                    valid;
      logic                    match;
      logic [`CAM_ADDR_W-1:0]  addr;
      logic [`CAM_DEPTH-1:0]   hits;
   } cam_result_t;
   typedef enum logic [1:0] {
      st_idle   = 2'b01,
      st_answer = 2'b10
   } cam_state_t;
endpackage

// file: hdl/cam_prio_enc.sv
// priority encoder: lowest hit index and any-hit flag
`timescale 1ns/1ps
module cam_prio_enc #(
   parameter int N  = 32,
   parameter int AW = 5
) (
   input  wire logic [N-1:0]  hits,  // per-entry match vector
   output logic [AW-1:0]      idx,   // lowest matching index
   output logic               any    // at least one hit
);
   always_comb
   begin
      idx = '0;
      any = 1'b0;
      // lowest index wins when several entries match
      for (int i = N-1; i >= 0; i--)
      begin
         if (hits[i])
         begin
            idx = AW'(i);
            any = 1'b1;
         end
      end
   end
endmodule

// file: hdl/cam_core.sv
// 32 x 32 content-addressable memory with per-bit don't-care
`timescale 1ns/1ps
`include "cam_defines.svh"
module cam_core
   import cam_pkg::*;
#(
   parameter int DEPTH = `CAM_DEPTH,
   parameter int WIDTH = `CAM_WIDTH,
   parameter int AW    = `CAM_ADDR_W
) (
   input  wire logic                 ref_clk, // system clock
   input  wire logic                 arst_n,  // async reset, active low
   input  wire cam_pkg::cam_write_t  wr,      // entry write request
   input  wire cam_pkg::cam_search_t srch,    // search request
   output cam_pkg::cam_result_t      res,     // registered lookup result
   output logic                      busy     // write and search clash
);
   import cam_pkg::*;

   logic [WIDTH-1:0]  data_ff [DEPTH];
   logic [WIDTH-1:0]  care_ff [DEPTH];
   logic [DEPTH-1:0]  used_ff;
   logic [DEPTH-1:0]  hits;
   logic [AW-1:0]     hit_idx;
   logic              hit_any;
   cam_state_t        state_ff;
   cam_state_t        nxt_state;
   logic              valid_ff;
   logic              match_ff;
   logic [AW-1:0]     addr_ff;
   logic [DEPTH-1:0]  hits_ff;
   logic [DEPTH-1:0]  below_addr;

   function automatic logic entry_hit(input logic [WIDTH-1:0] stored,
                                      input logic [WIDTH-1:0] care,
                                      input logic [WIDTH-1:0] key);
      // bits with care low are excluded from the compare
      entry_hit = ((stored ^ key) & care) == '0;
   endfunction

   // entry storage; data and mask written together
   always_ff @(posedge ref_clk)
   begin
      if (wr.en)
      begin
         data_ff[wr.addr] <= wr.data;
         care_ff[wr.addr] <= wr.care;
      end
   end

   // entries never written must not match an all-don't-care key
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         used_ff <= '0;
      else if (wr.en)
         used_ff[wr.addr] <= 1'b1;
   end

   // parallel compare of every entry in one cycle
   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
         hits[i] = used_ff[i] && entry_hit(data_ff[i], care_ff[i],
                                           srch.key);
   end

   cam_prio_enc #(
      .N  (DEPTH),
      .AW (AW)
   ) u_enc (
      .hits (hits),
      .idx  (hit_idx),
      .any  (hit_any)
   );

   // a search during a write sees the old contents; flag it to the user
   assign busy = wr.en && srch.en;

   // answer state marks a cycle in which a result stands
   always_comb
   begin
      case (state_ff)
         st_idle:   nxt_state = srch.en ? st_answer : st_idle;
         st_answer: nxt_state = srch.en ? st_answer : st_idle;
         default:   nxt_state = st_idle;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         state_ff <= st_idle;
      else
         state_ff <= nxt_state;
   end

   // result flops, one per concern; no-search cycles read as all zero
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         valid_ff <= 1'h0;
      else
         valid_ff <= srch.en;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         match_ff <= 1'h0;
      else
         match_ff <= srch.en && hit_any;
   end

   // a miss reports address zero, so a stale index never leaks out
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         addr_ff <= '0;
      else if (srch.en && hit_any)
         addr_ff <= hit_idx;
      else
         addr_ff <= '0;
   end

   // raw hit vector kept so several blocks can be merged outside
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         hits_ff <= '0;
      else if (srch.en)
         hits_ff <= hits;
      else
         hits_ff <= '0;
   end

   assign res = '{valid: valid_ff,
                  match: match_ff,
                  addr:  addr_ff,
                  hits:  hits_ff};

   // hits below the reported address; must be empty on a match
   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
         below_addr[i] = res.hits[i] && (i < int'(res.addr));
   end

   // assertions
   a_valid_follows: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      srch.en |=> res.valid)
      else $error("result valid missing one cycle after search");

   a_match_any_hit: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      srch.en |=> res.match == (|$past(hits)))
      else $error("match flag disagrees with hit vector");

   a_addr_is_hit: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      res.match |-> res.hits[res.addr])
      else $error("address does not point at a matching entry");

   a_nomatch_zero: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (res.valid && !res.match) |-> (res.addr == '0 && res.hits == '0))
      else $error("no-match result carries address or hits");

   a_idle_quiet: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      !srch.en |=> !res.valid && !res.match)
      else $error("result active without a search");

   a_dontcare_hit: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr.en && wr.care == '0 && !srch.en) ##1 (srch.en && !wr.en)
      |=> res.match)
      else $error("all don't-care entry failed to match");

   a_write_lookup: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr.en && wr.care == '1) ##1 (srch.en && !wr.en
      && srch.key == $past(wr.data)) |=> res.match)
      else $error("freshly written entry not found");

   a_state_track: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      res.valid |-> state_ff == st_answer)
      else $error("state and result valid disagree");

   a_lowest_hit: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      res.match |-> below_addr == '0)
      else $error("a lower matching entry was passed over");

   a_match_valid: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      res.match |-> res.valid)
      else $error("match flag raised outside a result");

   a_clash_old: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      (wr.en && srch.en && !used_ff[wr.addr])
      |=> !res.hits[$past(wr.addr)])
      else $error("search in a write cycle saw the new entry");

   a_unwritten_quiet: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      res.valid |-> (res.hits & ~$past(used_ff)) == '0)
      else $error("an unwritten entry reported a hit");

   a_hits_quiet: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      !res.valid |-> res.hits == '0)
      else $error("hit vector set without a result");
endmodule

// file: testbench/cam_user.sv
// user-side model issuing entry writes and searches
`timescale 1ns/1ps
module cam_user (
   input  wire logic            ref_clk, // system clock
   output cam_pkg::cam_write_t  wr,      // entry write request
   output cam_pkg::cam_search_t srch     // search request
);
   import cam_pkg::*;
   initial
   begin
      wr   = '0;
      srch = '0;
   end
   // one whole 32-bit word per request, held across the taking edge
   task automatic put(input logic        we,
                      input logic [4:0]  a,
                      input logic [31:0] d,
                      input logic [31:0] c,
                      input logic        se,
                      input logic [31:0] k);
      wr   = '{we, a, d, c};
      srch = '{se, k};
   endtask
   // let the taking edge pass, then wait the usual drive delay
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic req(input logic        we,
                      input logic [4:0]  a,
                      input logic [31:0] d,
                      input logic [31:0] c,
                      input logic        se,
                      input logic [31:0] k);
      put(we, a, d, c, se, k);
      step();
   endtask
   // released fields show the inverse, not a stale copy
   task automatic rest();
      wr   = '{1'b0, ~wr.addr, ~wr.data, ~wr.care};
      srch = '{1'b0, ~srch.key};
      step();
   endtask
endmodule

// file: testbench/content_addressable_memory_tb.sv
// self-checking bench for the content-addressable memory
`timescale 1ns/1ps
module content_addressable_memory_tb;
   import cam_pkg::*;
   logic        ref_clk   = 1'b0;
   logic        arst_n    = 1'b0;
   cam_write_t  wr;
   cam_search_t srch;
   cam_result_t res;
   logic        busy;
   int          error_cnt = 0;
   int          cmp_count = 0;
   always #4 ref_clk = ~ref_clk;
   cam_user usr (.ref_clk(ref_clk), .wr(wr), .srch(srch));
   cam_core DUT (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .wr      (wr),
      .srch    (srch),
      .res     (res),
      .busy    (busy)
   );
   task automatic chk(input string n, input logic [38:0] e);
      cmp_count++;
      if (res !== e)
      begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, res);
      end
   endtask
   // busy is combinational: look while the request still stands
   task automatic chk_busy(input string n, input logic e);
      cmp_count++;
      if (busy !== e)
      begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, busy);
      end
   endtask
   task automatic close_out();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic t_lookup();
      usr.req(1'h1, 5'h0e, 32'h0000fa12, '1, 1'h0, '0);
      usr.put(1'h0, 5'h00, '0, '0, 1'h1, 32'h0000fa12);
      #1;
      chk_busy("lone", 1'h0);
      usr.step();
      chk("hit", {2'h3, 5'h0e, 32'h00004000});
      usr.rest();
      chk("idle", '0);
      usr.req(1'h0, 5'h00, '0, '0, 1'h1, 32'h0000fa13);
      chk("miss", {2'h2, 5'h00, 32'h00000000});
      usr.rest();
   endtask
   task automatic t_mask();
      usr.req(1'h1, 5'h1f, 32'h12345670, 32'hfffffff0, 1'h0, '0);
      usr.req(1'h0, 5'h00, '0, '0, 1'h1, 32'h1234567f);
      chk("masked", {2'h3, 5'h1f, 32'h80000000});
      usr.req(1'h0, 5'h00, '0, '0, 1'h1, 32'h1234577f);
      chk("cared", {2'h2, 5'h00, 32'h00000000});
      usr.rest();
   endtask
   // all-don't-care entry matches every key, lowest index wins
   task automatic t_multi();
      usr.req(1'h1, 5'h03, '0, '0, 1'h0, '0);
      usr.req(1'h0, 5'h00, '0, '0, 1'h1, 32'h0000beef);
      chk("dontcare", {2'h3, 5'h03, 32'h00000008});
      usr.put(1'h1, 5'h07, 32'h0000beef, '1, 1'h1, 32'h0000beef);
      #1;
      chk_busy("clash", 1'h1);
      usr.step();
      chk("clash", {2'h3, 5'h03, 32'h00000008});
      usr.req(1'h0, 5'h00, '0, '0, 1'h1, 32'h0000beef);
      chk("multi", {2'h3, 5'h03, 32'h00000088});
      usr.rest();
   endtask
   // a mid-run reset forgets every entry and swallows a search
   task automatic t_reset();
      usr.req(1'h0, 5'h00, '0, '0, 1'h1, 32'h0000beef);
      chk("before", {2'h3, 5'h03, 32'h00000088});
      arst_n = 1'b0;
      usr.req(1'h0, 5'h00, '0, '0, 1'h1, 32'h0000beef);
      chk("reset", '0);
      arst_n = 1'b1;
      usr.req(1'h0, 5'h00, '0, '0, 1'h1, 32'h0000fa12);
      chk("cleared", {2'h2, 5'h00, 32'h00000000});
      usr.rest();
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      t_lookup();
      t_mask();
      t_multi();
      t_reset();
      close_out();
   end
   initial
   begin
      #100000;
      error_cnt++;
      close_out();
   end
endmodule
